// ---- core/lcis_cell.v ----
// configurable logic cell: input selection, gating, logic function, output polarity
// assumes a classic wishbone master on i_clk; pins and oscillator clocks are async
//
// How it works
// - 32 inputs reduce to four lines, one function
// - four independent 32-way multiplexers feed gating
// - each multiplexer has its own 5-bit select
// - codes 0-3 route the four cell pins
// - codes 4-7 route cell outputs one to four
// - codes 8-19 route the listed peripheral signals
// - codes 20-31 route serial, timers, flag, clocks
// - stages: selection, gating, function, output polarity
// - every stage setting writable at run time
// - output goes to peripherals and a pin
// - eight functions, combinational and storage forms
// - gates and true or inverted lines, optional invert
// - output polarity bit inverts function result
// - rising and falling edges each may flag
// - reset clears control, irq status and mask; keeps selection, gating, polarity
`timescale 1ns/1ps
`include "lcis_defs.vh"
module lcis_cell (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [31:0] i_wb_dat,
  input  wire [3:0]  i_wb_sel,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  input  wire [3:0]  i_cell_pin_input,
  input  wire [3:0]  i_cell_outputs,
  input  wire        i_comparator1_synced,
  input  wire        i_comparator2_synced,
  input  wire        i_waveform_gen_out_a,
  input  wire        i_waveform_gen_out_b,
  input  wire        i_capture1_output,
  input  wire        i_capture2_output,
  input  wire        i_pulse_width3_output,
  input  wire        i_pulse_width4_output,
  input  wire        i_sync_serial_clock,
  input  wire        i_sync_serial_data,
  input  wire        i_numeric_osc_output,
  input  wire        i_zero_cross_output,
  input  wire        i_async_serial_tx_clock,
  input  wire        i_async_serial_data,
  input  wire        i_timer4_period_hit,
  input  wire        i_timer6_period_hit,
  input  wire        i_timer0_wrap,
  input  wire        i_timer1_wrap,
  input  wire        i_timer2_period_hit,
  input  wire        i_pin_change_flag,
  input  wire        i_converter_rc_clock,
  input  wire        i_slow_internal_osc,
  input  wire        i_fast_internal_osc,
  input  wire        i_system_clock,
  output wire        o_cell_out,
  output wire        o_cell_pin_out,
  output wire        o_irq
);

  // ---------------------------------------------------------------- registers
  reg  [7:0] cell_control_reg;
  reg  [4:0] input_select_reg0;
  reg  [4:0] input_select_reg1;
  reg  [4:0] input_select_reg2;
  reg  [4:0] input_select_reg3;
  reg  [7:0] gate_select_reg0;
  reg  [7:0] gate_select_reg1;
  reg  [7:0] gate_select_reg2;
  reg  [7:0] gate_select_reg3;
  reg  [7:0] polarity_reg;
  reg        irq_status_reg;
  reg        irq_mask_reg;
  reg        cell_out_reg;
  reg        store_reg;
  reg        clk_gate_prev_reg;

  reg  [`LCIS_NUM_ASYNC-1:0] sync1_reg;
  reg  [`LCIS_NUM_ASYNC-1:0] sync2_reg;

  wire       bus_req;
  wire       wr_en;
  wire       rd_en;
  wire       cell_enable;
  wire [2:0] cell_mode;
  wire       rise_irq_enable;
  wire       fall_irq_enable;
  wire       cell_output_invert;

  assign bus_req            = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // only the low byte lane carries register data
  assign wr_en              = i_ce & bus_req & i_wb_we & i_wb_sel[0];
  assign rd_en              = i_ce & bus_req & ~i_wb_we;
  assign cell_enable        = cell_control_reg[`LCIS_CTRL_EN];
  assign cell_mode          = cell_control_reg[`LCIS_MODE_HI:`LCIS_MODE_LO];
  assign rise_irq_enable    = cell_control_reg[`LCIS_CTRL_RISE];
  assign fall_irq_enable    = cell_control_reg[`LCIS_CTRL_FALL];
  assign cell_output_invert = polarity_reg[`LCIS_POL_OUT];

  // ------------------------------------------------------- input resynchronisers
  // pins and oscillator clocks come from outside i_clk; a clock input is only
  // seen as well as i_clk can sample it, so fast oscillators alias
  wire [`LCIS_NUM_ASYNC-1:0] async_in;
  assign async_in = {i_system_clock, i_fast_internal_osc, i_slow_internal_osc,
                     i_converter_rc_clock, i_cell_pin_input};

  genvar s;
  generate
    for (s = 0; s < `LCIS_NUM_ASYNC; s = s + 1) begin : g_sync
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync1_reg[s] <= 1'b0;
          sync2_reg[s] <= 1'b0;
        end else if (i_ce) begin
          sync1_reg[s] <= async_in[s];
          sync2_reg[s] <= sync1_reg[s];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------ input vector
  wire [`LCIS_NUM_IN-1:0] cell_input_vector;
  assign cell_input_vector = {
    sync2_reg[7:4],
    i_pin_change_flag, i_timer2_period_hit,
    i_timer1_wrap, i_timer0_wrap,
    i_timer6_period_hit, i_timer4_period_hit,
    i_async_serial_data, i_async_serial_tx_clock,
    i_zero_cross_output, i_numeric_osc_output,
    i_sync_serial_data, i_sync_serial_clock,
    i_pulse_width4_output, i_pulse_width3_output,
    i_capture2_output, i_capture1_output,
    i_waveform_gen_out_b, i_waveform_gen_out_a,
    i_comparator2_synced, i_comparator1_synced,
    i_cell_outputs,
    sync2_reg[3:0]
  };

  // ------------------------------------------------------------ data selection
  wire [`LCIS_SEL_W*`LCIS_NUM_LINES-1:0] line_select_code;
  wire [`LCIS_NUM_LINES-1:0]             lines;
  assign line_select_code = {input_select_reg3, input_select_reg2,
                             input_select_reg1, input_select_reg0};

  genvar m;
  generate
    for (m = 0; m < `LCIS_NUM_LINES; m = m + 1) begin : g_mux
      lcis_input_mux u_mux (
        .i_cell_input_vector (cell_input_vector),
        .i_line_select_code  (line_select_code[`LCIS_SEL_W*m +: `LCIS_SEL_W]),
        .o_line              (lines[m])
      );
    end
  endgenerate

  // --------------------------------------------------------------- data gating
  wire [8*`LCIS_NUM_LINES-1:0] gate_enables;
  wire [`LCIS_NUM_LINES-1:0]   gates;
  assign gate_enables = {gate_select_reg3, gate_select_reg2,
                         gate_select_reg1, gate_select_reg0};

  genvar g;
  generate
    for (g = 0; g < `LCIS_NUM_LINES; g = g + 1) begin : g_gate
      lcis_gate u_gate (
        .i_lines   (lines),
        .i_enables (gate_enables[8*g +: 8]),
        .i_invert  (polarity_reg[`LCIS_POL_GATE_LO + g]),
        .o_gate    (gates[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------ logic function
  // gate 1 is the clock or latch enable of the storage forms other than SR; its edge is
  // taken against i_clk, so a storage form never sees two edges per cycle
  wire clk_rise;
  assign clk_rise = gates[0] & ~clk_gate_prev_reg;

  reg comb_fn;
  reg store_next;
  reg fn_out;
  always @* begin
    comb_fn    = 1'b0;
    store_next = store_reg;
    case (cell_mode)
      `LCIS_MODE_ANDOR: begin
        comb_fn = (gates[0] & gates[1]) | (gates[2] & gates[3]);
      end
      `LCIS_MODE_ORXOR: begin
        comb_fn = (gates[0] | gates[1]) ^ (gates[2] | gates[3]);
      end
      `LCIS_MODE_AND4: begin
        comb_fn = &gates;
      end
      `LCIS_MODE_SR: begin
        // reset dominates when both are asked for
        if (gates[2] | gates[3])
          store_next = 1'b0;
        else if (gates[0] | gates[1])
          store_next = 1'b1;
      end
      `LCIS_MODE_DSR: begin
        if (gates[2])
          store_next = 1'b0;
        else if (gates[3])
          store_next = 1'b1;
        else if (clk_rise)
          store_next = gates[1];
      end
      `LCIS_MODE_DR: begin
        if (gates[2] | gates[3])
          store_next = 1'b0;
        else if (clk_rise)
          store_next = gates[1];
      end
      `LCIS_MODE_JKR: begin
        if (gates[2])
          store_next = 1'b0;
        else if (clk_rise) begin
          case ({gates[1], gates[3]})
            2'b10:   store_next = 1'b1;
            2'b01:   store_next = 1'b0;
            2'b11:   store_next = ~store_reg;
            default: store_next = store_reg;
          endcase
        end
      end
      `LCIS_MODE_LATSR: begin
        if (gates[2])
          store_next = 1'b0;
        else if (gates[3])
          store_next = 1'b1;
        else if (gates[0])
          store_next = gates[1];
      end
      default: begin
        comb_fn = 1'b0;
      end
    endcase
    if (cell_mode == `LCIS_MODE_ANDOR || cell_mode == `LCIS_MODE_ORXOR ||
        cell_mode == `LCIS_MODE_AND4)
      fn_out = comb_fn;
    else
      fn_out = store_next;
  end

  // ----------------------------------------------------------- output polarity
  // a disabled cell drives low, so nothing undefined leaves before setup
  wire cell_out_next;
  assign cell_out_next = cell_enable & (fn_out ^ cell_output_invert);

  wire edge_rise;
  wire edge_fall;
  wire irq_event;
  assign edge_rise = cell_out_next & ~cell_out_reg;
  assign edge_fall = ~cell_out_next & cell_out_reg;
  // a polarity change while enabled flags like any other output edge
  assign irq_event = (edge_rise & rise_irq_enable) | (edge_fall & fall_irq_enable);

  assign o_cell_out     = cell_out_reg;
  assign o_cell_pin_out = cell_out_reg;
  assign o_irq          = irq_status_reg & irq_mask_reg;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cell_out_reg      <= 1'b0;
      store_reg         <= 1'b0;
      clk_gate_prev_reg <= 1'b0;
    end else if (i_ce) begin
      cell_out_reg      <= cell_out_next;
      store_reg         <= cell_enable ? store_next : 1'b0;
      clk_gate_prev_reg <= gates[0];
    end
  end

  // ------------------------------------------------------- control and status
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cell_control_reg <= `LCIS_CTRL_RST;
      irq_status_reg   <= `LCIS_STAT_RST;
      irq_mask_reg     <= `LCIS_MASK_RST;
    end else if (i_ce) begin
      if (wr_en && i_wb_adr == `LCIS_ADR_CTRL) begin
        cell_control_reg <= i_wb_dat[7:0];
        cell_control_reg[`LCIS_CTRL_OUT] <= 1'b0;
        cell_control_reg[`LCIS_CTRL_RSVD] <= 1'b0;
      end
      if (wr_en && i_wb_adr == `LCIS_ADR_MASK)
        irq_mask_reg <= i_wb_dat[`LCIS_STAT_IRQ];
      // a new edge in the cycle of the clearing read still sets the flag
      if (irq_event)
        irq_status_reg <= 1'b1;
      else if (rd_en && i_wb_adr == `LCIS_ADR_STAT)
        irq_status_reg <= 1'b0;
    end
  end

  // selection, gating and polarity keep their values through reset and power
  // up undefined, so software must load them before enabling the cell
  always @(posedge i_clk) begin
    if (i_ce && wr_en) begin
      case (i_wb_adr)
        `LCIS_ADR_SEL0:  input_select_reg0 <= i_wb_dat[`LCIS_SEL_W-1:0];
        `LCIS_ADR_SEL1:  input_select_reg1 <= i_wb_dat[`LCIS_SEL_W-1:0];
        `LCIS_ADR_SEL2:  input_select_reg2 <= i_wb_dat[`LCIS_SEL_W-1:0];
        `LCIS_ADR_SEL3:  input_select_reg3 <= i_wb_dat[`LCIS_SEL_W-1:0];
        `LCIS_ADR_GATE0: gate_select_reg0  <= i_wb_dat[7:0];
        `LCIS_ADR_GATE1: gate_select_reg1  <= i_wb_dat[7:0];
        `LCIS_ADR_GATE2: gate_select_reg2  <= i_wb_dat[7:0];
        `LCIS_ADR_GATE3: gate_select_reg3  <= i_wb_dat[7:0];
        `LCIS_ADR_POL:   polarity_reg      <= i_wb_dat[7:0];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------ wishbone reads
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (i_wb_adr)
      `LCIS_ADR_CTRL: begin
        rd_byte = cell_control_reg;
        rd_byte[`LCIS_CTRL_OUT] = cell_out_reg;
      end
      `LCIS_ADR_SEL0:  rd_byte = {3'h0, input_select_reg0};
      `LCIS_ADR_SEL1:  rd_byte = {3'h0, input_select_reg1};
      `LCIS_ADR_SEL2:  rd_byte = {3'h0, input_select_reg2};
      `LCIS_ADR_SEL3:  rd_byte = {3'h0, input_select_reg3};
      `LCIS_ADR_GATE0: rd_byte = gate_select_reg0;
      `LCIS_ADR_GATE1: rd_byte = gate_select_reg1;
      `LCIS_ADR_GATE2: rd_byte = gate_select_reg2;
      `LCIS_ADR_GATE3: rd_byte = gate_select_reg3;
      `LCIS_ADR_POL:   rd_byte = {polarity_reg[`LCIS_POL_OUT], 3'h0,
                                  polarity_reg[`LCIS_POL_GATE_HI:`LCIS_POL_GATE_LO]};
      `LCIS_ADR_STAT:  rd_byte = {7'h00, irq_status_reg};
      `LCIS_ADR_MASK:  rd_byte = {7'h00, irq_mask_reg};
      default:         rd_byte = 8'h00;
    endcase
  end

  // one wait state: ack and data register on the edge that takes the request;
  // unmapped addresses are acknowledged and read as zero
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else if (i_ce) begin
      o_wb_ack <= bus_req;
      if (rd_en)
        o_wb_dat <= {24'h000000, rd_byte};
    end
  end

endmodule

// ---- core/lcis_defs.vh ----
// constants for the logic cell: register map, field positions, reset values, modes
// assumes byte addresses on a 32-bit wishbone bus, one register per aligned word
`ifndef LCIS_DEFS_VH
`define LCIS_DEFS_VH

`define LCIS_ADR_W        8
`define LCIS_ADR_CTRL     8'h00
`define LCIS_ADR_SEL0     8'h04
`define LCIS_ADR_SEL1     8'h08
`define LCIS_ADR_SEL2     8'h0c
`define LCIS_ADR_SEL3     8'h10
`define LCIS_ADR_GATE0    8'h14
`define LCIS_ADR_GATE1    8'h18
`define LCIS_ADR_GATE2    8'h1c
`define LCIS_ADR_GATE3    8'h20
`define LCIS_ADR_POL      8'h24
`define LCIS_ADR_STAT     8'h28
`define LCIS_ADR_MASK     8'h2c

`define LCIS_CTRL_RST     8'h00
`define LCIS_CTRL_EN      7
`define LCIS_CTRL_OUT     5
`define LCIS_CTRL_RSVD    6
`define LCIS_CTRL_RISE    4
`define LCIS_CTRL_FALL    3
`define LCIS_MODE_HI      2
`define LCIS_MODE_LO      0
`define LCIS_POL_OUT      7
`define LCIS_POL_GATE_HI  3
`define LCIS_POL_GATE_LO  0
`define LCIS_STAT_IRQ     0
`define LCIS_STAT_RST     1'h0
`define LCIS_MASK_RST     1'h0

`define LCIS_SEL_W        5
`define LCIS_NUM_IN       32
`define LCIS_NUM_LINES    4
`define LCIS_NUM_ASYNC    8

`define LCIS_MODE_ANDOR   3'h0
`define LCIS_MODE_ORXOR   3'h1
`define LCIS_MODE_AND4    3'h2
`define LCIS_MODE_SR      3'h3
`define LCIS_MODE_DSR     3'h4
`define LCIS_MODE_DR      3'h5
`define LCIS_MODE_JKR     3'h6
`define LCIS_MODE_LATSR   3'h7

`endif

// ---- core/lcis_gate.v ----
// one data gate: any mix of the four lines, each true or inverted, plus polarity
// assumes enable byte pairs per line: bit 2k takes line k inverted, bit 2k+1 true
`timescale 1ns/1ps
`include "lcis_defs.vh"
module lcis_gate (
  input  wire [`LCIS_NUM_LINES-1:0]   i_lines,
  input  wire [2*`LCIS_NUM_LINES-1:0] i_enables,
  input  wire                         i_invert,
  output wire                         o_gate
);
  wire [2*`LCIS_NUM_LINES-1:0] terms;
  genvar k;
  generate
    for (k = 0; k < `LCIS_NUM_LINES; k = k + 1) begin : g_term
      assign terms[2*k]   = i_enables[2*k] & ~i_lines[k];
      assign terms[2*k+1] = i_enables[2*k+1] & i_lines[k];
    end
  endgenerate
  // or of the selected terms is the de morgan form of the and of their complements;
  // with nothing enabled the gate rests at its polarity bit
  assign o_gate = (|terms) ^ i_invert;
endmodule

// ---- core/lcis_input_mux.v ----
// one 32-way data selection multiplexer of the logic cell
// assumes the input vector is already in the cell's clock domain
`timescale 1ns/1ps
`include "lcis_defs.vh"
module lcis_input_mux (
  input  wire [`LCIS_NUM_IN-1:0] i_cell_input_vector,
  input  wire [`LCIS_SEL_W-1:0]  i_line_select_code,
  output wire                    o_line
);
  // code value is the index of the chosen input; no register on the path
  assign o_line = i_cell_input_vector[i_line_select_code];
endmodule

// ---- verification/lcis_cell_sva.sv ----
// checker of the logic cell top: bus handshake, pin copy, irq and enable gating
// assumes it is bound to lcis_cell and sees only that module's ports
`timescale 1ns/1ps
`include "lcis_defs.vh"
module lcis_cell_sva (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        o_cell_out,
  input wire logic        o_cell_pin_out,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic take_w;
  logic en_q;
  logic mask_q;
  assign take_w = i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce;
  // shadows of enable and mask, so output and irq gating can be judged
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_q   <= 1'b0;
      mask_q <= 1'b0;
    end else if (take_w && i_wb_we && i_wb_sel[0]) begin
      if (i_wb_adr == `LCIS_ADR_CTRL) en_q <= i_wb_dat[7];
      if (i_wb_adr == `LCIS_ADR_MASK) mask_q <= i_wb_dat[0];
    end
  end
  ack_latency_a: assert property (take_w |=> o_wb_ack)
    else $error("ack missing after request");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (o_wb_ack |-> $past(take_w))
    else $error("ack without request");
  rdata_width_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("read data upper bits set");
  pin_copy_a: assert property (o_cell_pin_out == o_cell_out)
    else $error("pin output differs from cell output");
  out_off_a: assert property ((!en_q) [*3] |-> !o_cell_out)
    else $error("disabled cell drives output");
  irq_mask_a: assert property (o_irq |-> mask_q)
    else $error("irq while masked");
  irq_hold_a: assert property (o_irq && !i_wb_cyc |=> o_irq)
    else $error("irq dropped without bus access");
  irq_rst_a: assert property ($rose(i_rst_n) |-> !o_irq)
    else $error("irq high after reset");
  ce_freeze_a: assert property (!i_ce |=> $stable(o_cell_out) && $stable(o_wb_ack) && $stable(o_irq))
    else $error("state moved while clock enable low");
  cover property (o_wb_ack);
  cover property ($rose(o_irq));
  cover property ($rose(o_cell_out));
endmodule
bind lcis_cell lcis_cell_sva u_sva (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
  .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .o_cell_out(o_cell_out), .o_cell_pin_out(o_cell_pin_out), .o_irq(o_irq)
);

// ---- verification/lcis_src_model.sv ----
// far-side sources of the logic cell: pins, peripherals, timers, clocks
// assumes the bench supplies the next level of all 32 sources each cycle
`timescale 1ns/1ps
module lcis_src_model (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_val,
  output logic      [31:0] o_src
);
  // one register stage, like a peripheral output flop feeding the cell
  always @(posedge i_clk) begin
    o_src <= i_val;
  end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench of the logic cell: every select code, gating, polarity, irq
// assumes lcis_cell as device, lcis_src_model as source side, 125 MHz clock
`timescale 1ns/1ps
`include "lcis_defs.vh"
module testbench;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        cyc = 0;
  logic        stb = 0;
  logic        ce = 1;
  logic        we = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] val = 32'h0;
  logic [31:0] rng = 32'h2f2c;
  logic [31:0] q;
  logic [31:0] rdat;
  logic [31:0] src;
  logic        ack;
  logic        out;
  logic        pout;
  logic        irq;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #4 clk = ~clk;
  lcis_src_model u_src (.i_clk(clk), .i_val(val), .o_src(src));
  lcis_cell u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_cell_pin_input(src[3:0]), .i_cell_outputs(src[7:4]),
    .i_comparator1_synced(src[8]), .i_comparator2_synced(src[9]),
    .i_waveform_gen_out_a(src[10]), .i_waveform_gen_out_b(src[11]),
    .i_capture1_output(src[12]), .i_capture2_output(src[13]),
    .i_pulse_width3_output(src[14]), .i_pulse_width4_output(src[15]),
    .i_sync_serial_clock(src[16]), .i_sync_serial_data(src[17]),
    .i_numeric_osc_output(src[18]), .i_zero_cross_output(src[19]),
    .i_async_serial_tx_clock(src[20]), .i_async_serial_data(src[21]),
    .i_timer4_period_hit(src[22]), .i_timer6_period_hit(src[23]),
    .i_timer0_wrap(src[24]), .i_timer1_wrap(src[25]), .i_timer2_period_hit(src[26]),
    .i_pin_change_flag(src[27]), .i_converter_rc_clock(src[28]),
    .i_slow_internal_osc(src[29]), .i_fast_internal_osc(src[30]),
    .i_system_clock(src[31]), .o_cell_out(out), .o_cell_pin_out(pout), .o_irq(irq)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic exp_line(input logic [31:0] v, input logic [4:0] c, input logic inv);
    return v[c] ^ inv;
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= 4'hf;
    @(posedge clk);
    // ends on ack; a missing ack is ended only by the bench timeout
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cfg(input logic [7:0] g, input logic [7:0] pol);
    wb(1'b1, `LCIS_ADR_GATE0, g);
    wb(1'b1, `LCIS_ADR_GATE1, g);
    wb(1'b1, `LCIS_ADR_GATE2, 8'h00);
    wb(1'b1, `LCIS_ADR_GATE3, 8'h00);
    wb(1'b1, `LCIS_ADR_POL, pol);
    wb(1'b1, `LCIS_ADR_CTRL, 8'h80);
  endtask
  // both levels of the chosen source, other sources random
  task automatic try(input int k, input logic [4:0] c, input logic inv);
    logic [31:0] v;
    wb(1'b1, `LCIS_ADR_SEL0 + 8'(4 * k), {3'h0, c});
    for (int b = 0; b < 2; b++) begin
      rng = xs(rng);
      v = b ? (rng | (32'h1 << c)) : (rng & ~(32'h1 << c));
      val <= v;
      repeat (6) @(posedge clk);
      chk("cell_out", {31'h0, exp_line(v, c, inv)}, {31'h0, out});
      chk("cell_pin", {31'h0, exp_line(v, c, inv)}, {31'h0, pout});
    end
  endtask
  // level after gates g settle; p is gate 1 before, s the stored level
  function automatic logic exp_fn(input logic [2:0] m, input logic [3:0] g, input logic p,
                                  input logic s);
    logic up;
    up = g[0] & ~p;
    case (m)
      `LCIS_MODE_ANDOR: return (g[0] & g[1]) | (g[2] & g[3]);
      `LCIS_MODE_ORXOR: return (g[0] | g[1]) ^ (g[2] | g[3]);
      `LCIS_MODE_AND4:  return &g;
      `LCIS_MODE_SR:    return (g[2] | g[3]) ? 1'b0 : ((g[0] | g[1]) | s);
      `LCIS_MODE_DSR:   return g[2] ? 1'b0 : (g[3] | (up ? g[1] : s));
      `LCIS_MODE_DR:    return (g[2] | g[3]) ? 1'b0 : (up ? g[1] : s);
      `LCIS_MODE_JKR:   return g[2] ? 1'b0 : (up ? ((g[1] & ~s) | (~g[3] & s)) : s);
      default:          return g[2] ? 1'b0 : (g[3] | (g[0] ? g[1] : s));
    endcase
  endfunction
  // one function from a cleared store; gate k follows line k, lines from sources 8-11
  task automatic mode_run(input logic [2:0] m);
    logic [3:0] g;
    logic       p;
    logic       s;
    p = 1'b0;
    s = 1'b0;
    val <= 32'h0;
    wb(1'b1, `LCIS_ADR_CTRL, 8'h00);
    wb(1'b1, `LCIS_ADR_CTRL, {5'h10, m});
    for (int n = 0; n < 12; n++) begin
      rng = xs(rng);
      g = rng[3:0];
      val <= {20'h0, g, 8'h00};
      repeat (3) @(posedge clk);
      s = exp_fn(m, g, p, s);
      p = g[0];
      chk("mode_out", {31'h0, s}, {31'h0, out});
    end
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 4; k++) wb(1'b1, `LCIS_ADR_SEL0 + 8'(4 * k), 8'h00);
    cfg(8'h02, 8'h00);
    for (int c = 0; c < 32; c++) try(0, c[4:0], 1'b0);
    for (int k = 1; k < 4; k++) begin
      cfg(8'h02 << (2 * k), 8'h00);
      for (int j = 0; j < 6; j++) begin
        rng = xs(rng);
        try(k, rng[4:0], 1'b0);
      end
    end
    cfg(8'h02, 8'h80);
    try(0, 5'h08, 1'b1);
    cfg(8'h01, 8'h00);
    try(0, 5'h09, 1'b1);
    cfg(8'h01, 8'h03);
    try(0, 5'h0a, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, `LCIS_ADR_SEL0 + 8'(4 * k), 8'(8 + k));
      wb(1'b1, `LCIS_ADR_GATE0 + 8'(4 * k), 8'h02 << (2 * k));
    end
    wb(1'b1, `LCIS_ADR_POL, 8'h00);
    for (int m = 0; m < 8; m++) mode_run(m[2:0]);
    cfg(8'h02, 8'h00);
    wb(1'b1, `LCIS_ADR_SEL0, 8'h08);
    val <= 32'h0;
    repeat (6) @(posedge clk);
    wb(1'b1, `LCIS_ADR_CTRL, 8'h90);
    wb(1'b0, `LCIS_ADR_STAT, 8'h00);
    wb(1'b1, `LCIS_ADR_MASK, 8'h01);
    val <= 32'h100;
    repeat (6) @(posedge clk);
    chk("irq_rise", 32'h1, {31'h0, irq});
    wb(1'b0, `LCIS_ADR_STAT, 8'h00);
    chk("stat", 32'h1, {31'h0, q[0]});
    chk("irq_clear", 32'h0, {31'h0, irq});
    val <= 32'h0;
    repeat (6) @(posedge clk);
    chk("irq_fall", 32'h0, {31'h0, irq});
    wb(1'b1, `LCIS_ADR_MASK, 8'h00);
    val <= 32'h100;
    repeat (6) @(posedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wb(1'b1, `LCIS_ADR_MASK, 8'h01);
    chk("irq_unmask", 32'h1, {31'h0, irq});
    // clock enable low freezes the output although its source falls
    ce <= 1'b0;
    val <= 32'h0;
    repeat (6) @(posedge clk);
    chk("ce_hold", 32'h1, {31'h0, out});
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ce_run", 32'h0, {31'h0, out});
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, `LCIS_ADR_CTRL, 8'h00);
    chk("ctrl_rst", 32'h0, q);
    wb(1'b0, `LCIS_ADR_SEL0, 8'h00);
    chk("sel_kept", 32'h8, {27'h0, q[4:0]});
    wb(1'b0, 8'h40, 8'h00);
    chk("unmapped", 32'h0, q);
    stop_test();
  end
endmodule
